// ==== common/timer_two_pkg.sv ====
// Purpose: Shared constants for the up/down reload clock-out timer
// Assumes: clk_in is the oscillator clock, 25 MHz
// Notes:   Register byte address is four times the register index

package timer_two_pkg;

  // ---------------------------------------------------------------
  // Clocking
  // ---------------------------------------------------------------
  localparam int unsigned FOSC_HZ      = 25_000_000;
  localparam int unsigned TIMER_DIVIDE = 12;
  localparam int unsigned FAST_DIVIDE  = 2;

  // ---------------------------------------------------------------
  // Register indices (byte address = index * 4)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_CONTROL     = 8'hc8;
  localparam logic [7:0] IDX_MODE        = 8'hc9;
  localparam logic [7:0] IDX_COUNT_LOW   = 8'hca;
  localparam logic [7:0] IDX_COUNT_HIGH  = 8'hcb;
  localparam logic [7:0] IDX_RELOAD_LOW  = 8'hcc;
  localparam logic [7:0] IDX_RELOAD_HIGH = 8'hcd;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned CTL_OVERFLOW   = 7;
  localparam int unsigned CTL_EXTERNAL   = 6;
  localparam int unsigned CTL_RX_CLOCK   = 5;
  localparam int unsigned CTL_TX_CLOCK   = 4;
  localparam int unsigned CTL_EXT_ENABLE = 3;
  localparam int unsigned CTL_RUN        = 2;
  localparam int unsigned CTL_COUNTER    = 1;
  localparam int unsigned CTL_CAPTURE    = 0;
  localparam int unsigned MOD_CLOCK_OE   = 1;
  localparam int unsigned MOD_UPDOWN     = 0;

  // ---------------------------------------------------------------
  // Reset values and fixed codes
  // ---------------------------------------------------------------
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [1:0]  MODE_RESET    = 2'h0;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [15:0] RELOAD_RESET  = 16'h0000;
  localparam logic [15:0] COUNT_MAX     = 16'hffff;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'h0;

  typedef enum logic [2:0] {
    SEL_NONE, SEL_CONTROL, SEL_MODE, SEL_COUNT_LOW, SEL_COUNT_HIGH, SEL_RELOAD_LOW, SEL_RELOAD_HIGH
  } reg_sel_t;

endpackage

// ==== src/count_prescaler.sv ====
// Purpose: Divides the oscillator into slow and fast count ticks
// Assumes: DIVIDE is even so the fast tick lines up with the slow one
// Notes:   Ticks are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none

module count_prescaler #(
  parameter int unsigned DIVIDE = 12
) (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  output logic      slow_tick_out,
  output logic      fast_tick_out
);

  if (DIVIDE < 2 || DIVIDE > 255 || (DIVIDE % 2) != 0) begin : g_bad_divide
    $error("count_prescaler: DIVIDE must be even and in 2..254");
  end

  localparam logic [7:0] LAST = 8'(DIVIDE - 1);

  logic [7:0] div_r, div_nxt;
  logic       half_r, half_nxt;

  always_comb begin
    div_nxt  = (div_r == LAST) ? 8'h00 : div_r + 8'h01;
    half_nxt = ~half_r;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_r  <= 8'h00;
      half_r <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      half_r <= half_nxt;
    end
  end

  assign slow_tick_out = (div_r == LAST);
  assign fast_tick_out = half_r;

endmodule // count_prescaler
`default_nettype wire

// ==== src/edge_sync.sv ====
// Purpose: Two-flop synchroniser with falling-edge detector
// Assumes: pin_in may be asynchronous to clk_in
// Notes:   fall_out is a one-cycle pulse, one to two cycles late
`timescale 1ns/1ps
`default_nettype none

module edge_sync (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  input  wire logic pin_in,
  output logic      level_out,
  output logic      fall_out
);

  logic meta_r, sync_r, last_r;
  logic meta_nxt, sync_nxt, last_nxt;

  always_comb begin
    meta_nxt = pin_in;
    sync_nxt = meta_r;
    last_nxt = sync_r;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      last_r <= 1'b1;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      last_r <= last_nxt;
    end
  end

  assign level_out = sync_r;
  assign fall_out  = last_r & ~sync_r;

endmodule // edge_sync
`default_nettype wire

// ==== src/updown_reload_clockout_timer.sv ====
// Purpose: 16-bit timer/counter with capture, auto-reload (up/down),
//          serial clock generation and clock-out, on an AHB-Lite slave
// Assumes: clk_in is the oscillator; single word transfers only
// Notes:   Zero wait states; unmapped addresses read zero, writes dropped
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module updown_reload_clockout_timer
  import timer_two_pkg::*;
#(
  parameter int unsigned COUNT_W = 16,
  parameter int unsigned DIVIDE  = TIMER_DIVIDE
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        count_pin_in,
  output logic             count_pin_out,
  output logic             count_pin_oe_out,
  input  wire logic        direction_capture_pin_in,
  output logic             timer_irq_out,
  output logic             serial_clock_tick_out
);

  if (COUNT_W != 16 || DIVIDE != TIMER_DIVIDE) begin : g_bad_param
    $error("updown_reload_clockout_timer: only a 16-bit count divided by 12 is supported");
  end

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  function automatic reg_sel_t decode_sel(input logic [31:0] addr);
    reg_sel_t   sel;
    logic [7:0] idx;
    idx = addr[9:2];
    sel = SEL_NONE;
    if (addr[31:10] == 22'h0 && addr[1:0] == 2'h0) begin
      if (idx == IDX_CONTROL)     sel = SEL_CONTROL;
      if (idx == IDX_MODE)        sel = SEL_MODE;
      if (idx == IDX_COUNT_LOW)   sel = SEL_COUNT_LOW;
      if (idx == IDX_COUNT_HIGH)  sel = SEL_COUNT_HIGH;
      if (idx == IDX_RELOAD_LOW)  sel = SEL_RELOAD_LOW;
      if (idx == IDX_RELOAD_HIGH) sel = SEL_RELOAD_HIGH;
    end
    return sel;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0]  ctl_r, ctl_nxt;
  logic [1:0]  mode_r, mode_nxt;
  logic [15:0] count_r, count_nxt;
  logic [15:0] reload_r, reload_nxt;
  logic        clk_pin_r, clk_pin_nxt;
  logic        pin_oe_r, pin_oe_nxt;
  logic        irq_r, irq_nxt;
  logic        ser_tick_r, ser_tick_nxt;
  logic        wr_pend_r, wr_pend_nxt;
  reg_sel_t    wr_sel_r, wr_sel_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  logic slow_tick, fast_tick, count_fall, dir_level, dir_fall;
  logic serial, clkout, capture_mode, updown, src_tick, step, count_up;
  logic wrap_up, wrap_down, wrap, ext_event, accept;
  logic sw_ctl, sw_count, sw_reload;
  reg_sel_t rd_sel;

  count_prescaler #(.DIVIDE(DIVIDE)) u_prescaler (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .slow_tick_out (slow_tick),
    .fast_tick_out (fast_tick)
  );

  edge_sync u_count_sync (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .pin_in    (count_pin_in),
    .level_out (),
    .fall_out  (count_fall)
  );

  edge_sync u_dir_sync (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .pin_in    (direction_capture_pin_in),
    .level_out (dir_level),
    .fall_out  (dir_fall)
  );

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  assign serial       = ctl_r[CTL_RX_CLOCK] | ctl_r[CTL_TX_CLOCK];
  assign clkout       = mode_r[MOD_CLOCK_OE] & ~ctl_r[CTL_COUNTER];
  assign capture_mode = ctl_r[CTL_CAPTURE] & ~serial;
  assign updown       = mode_r[MOD_UPDOWN] & ~capture_mode & ~serial;
  // Pin events are ignored while the pin is driven as a clock output
  assign src_tick     = ctl_r[CTL_COUNTER] ? (count_fall & ~mode_r[MOD_CLOCK_OE])
                      : ((serial | clkout) ? fast_tick : slow_tick);
  assign step         = ctl_r[CTL_RUN] & src_tick;
  assign count_up     = ~updown | dir_level;
  assign wrap_up      = step & count_up & (count_r == COUNT_MAX);
  assign wrap_down    = step & ~count_up & (count_r == reload_r);
  assign wrap         = wrap_up | wrap_down;
  // In up/down mode the pin is the direction, so its edges do nothing else
  assign ext_event    = ctl_r[CTL_EXT_ENABLE] & dir_fall & ~updown;
  assign accept       = hsel_in & hready_in & htrans_in[1];
  assign rd_sel       = decode_sel(haddr_in);
  assign sw_ctl       = wr_pend_r & (wr_sel_r == SEL_CONTROL);
  assign sw_count     = wr_pend_r & (wr_sel_r == SEL_COUNT_LOW || wr_sel_r == SEL_COUNT_HIGH);
  assign sw_reload    = wr_pend_r & (wr_sel_r == SEL_RELOAD_LOW || wr_sel_r == SEL_RELOAD_HIGH);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    ctl_nxt      = ctl_r;
    mode_nxt     = mode_r;
    count_nxt    = count_r;
    reload_nxt   = reload_r;
    clk_pin_nxt  = clk_pin_r;
    pin_oe_nxt   = 1'b0;
    ser_tick_nxt = 1'b0;
    irq_nxt      = 1'b0;
    wr_pend_nxt  = accept & hwrite_in;
    wr_sel_nxt   = accept ? rd_sel : SEL_NONE;
    rdata_nxt    = 32'h0000_0000;

    // Counting; the byte carry falls out of the 16-bit add
    if (step) begin
      if (count_up) begin
        if (wrap_up) begin
          count_nxt = capture_mode ? COUNT_RESET : reload_r;
        end else begin
          count_nxt = count_r + 16'h0001;
        end
      end else begin
        count_nxt = wrap_down ? COUNT_MAX : count_r - 16'h0001;
      end
    end

    // External pin edge beats a coincident wrap
    if (ext_event && !serial) begin
      if (capture_mode) begin
        reload_nxt = count_r;
      end else begin
        count_nxt = reload_r;
      end
    end

    // Clock-out toggles per wrap: period is 2 x (65536 - reload) fast ticks
    if (!clkout) begin
      clk_pin_nxt = 1'b0;
    end else if (wrap) begin
      clk_pin_nxt = ~clk_pin_r;
    end
    pin_oe_nxt   = mode_nxt[MOD_CLOCK_OE] & ~ctl_nxt[CTL_COUNTER];
    ser_tick_nxt = wrap & serial;

    // Software writes win over counting on the same cycle
    if (wr_pend_r) begin
      unique case (wr_sel_r)
        SEL_CONTROL:     ctl_nxt = hwdata_in[7:0];
        SEL_MODE:        mode_nxt = hwdata_in[1:0];
        SEL_COUNT_LOW:   count_nxt[7:0] = hwdata_in[7:0];
        SEL_COUNT_HIGH:  count_nxt[15:8] = hwdata_in[7:0];
        SEL_RELOAD_LOW:  reload_nxt[7:0] = hwdata_in[7:0];
        SEL_RELOAD_HIGH: reload_nxt[15:8] = hwdata_in[7:0];
        SEL_NONE:        ;
      endcase
    end

    // Hardware flag sets win over a software clear
    if (wrap && !serial && !clkout) begin
      ctl_nxt[CTL_OVERFLOW] = 1'b1;
    end
    if (updown && wrap) begin
      ctl_nxt[CTL_EXTERNAL] = ~ctl_nxt[CTL_EXTERNAL];
    end else if (ext_event) begin
      ctl_nxt[CTL_EXTERNAL] = 1'b1;
    end
    irq_nxt = ctl_nxt[CTL_OVERFLOW] | (ctl_nxt[CTL_EXTERNAL] & ~mode_nxt[MOD_UPDOWN]);

    // Read data from next values so a read right behind a write sees it
    if (accept && !hwrite_in) begin
      unique case (rd_sel)
        SEL_CONTROL:     rdata_nxt = {24'h0, ctl_nxt};
        SEL_MODE:        rdata_nxt = {30'h0, mode_nxt};
        SEL_COUNT_LOW:   rdata_nxt = {24'h0, count_nxt[7:0]};
        SEL_COUNT_HIGH:  rdata_nxt = {24'h0, count_nxt[15:8]};
        SEL_RELOAD_LOW:  rdata_nxt = {24'h0, reload_nxt[7:0]};
        SEL_RELOAD_HIGH: rdata_nxt = {24'h0, reload_nxt[15:8]};
        SEL_NONE:        rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctl_r      <= CONTROL_RESET;
      mode_r     <= MODE_RESET;
      count_r    <= COUNT_RESET;
      reload_r   <= RELOAD_RESET;
      clk_pin_r  <= 1'b0;
      pin_oe_r   <= 1'b0;
      ser_tick_r <= 1'b0;
      irq_r      <= 1'b0;
      wr_pend_r  <= 1'b0;
      wr_sel_r   <= SEL_NONE;
      rdata_r    <= 32'h0000_0000;
    end else begin
      ctl_r      <= ctl_nxt;
      mode_r     <= mode_nxt;
      count_r    <= count_nxt;
      reload_r   <= reload_nxt;
      clk_pin_r  <= clk_pin_nxt;
      pin_oe_r   <= pin_oe_nxt;
      ser_tick_r <= ser_tick_nxt;
      irq_r      <= irq_nxt;
      wr_pend_r  <= wr_pend_nxt;
      wr_sel_r   <= wr_sel_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Bus response
  // ---------------------------------------------------------------
  logic ready_r, resp_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ready_r <= 1'b1;
      resp_r  <= HRESP_OKAY;
    end else begin
      ready_r <= 1'b1;
      resp_r  <= HRESP_OKAY;
    end
  end

  assign hrdata_out            = rdata_r;
  assign hreadyout_out         = ready_r;
  assign hresp_out             = resp_r;
  assign count_pin_out         = clk_pin_r;
  assign count_pin_oe_out      = pin_oe_r;
  assign timer_irq_out         = irq_r;
  assign serial_clock_tick_out = ser_tick_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  run_hold_a: assert property (!ctl_r[CTL_RUN] && !ext_event && !sw_count |=> $stable(count_r))
    else $error("count moved while stopped");
  timer_div_a: assert property (slow_tick |=> (!slow_tick)[*8] ##1 !slow_tick ##1 !slow_tick
                                ##1 !slow_tick ##1 slow_tick)
    else $error("timer tick spacing is not twelve");
  cascade_a: assert property (step && count_up && count_r[7:0] == 8'hff && !wrap_up && !ext_event && !sw_count
                              |=> count_r[15:8] == $past(count_r[15:8]) + 8'h01 && count_r[7:0] == 8'h00)
    else $error("low byte did not carry into high byte");
  up_reload_a: assert property (wrap_up && !capture_mode && !ext_event && !sw_count
                                |=> count_r == $past(reload_r))
    else $error("overflow did not load reload pair");
  down_wrap_a: assert property (wrap_down && !ext_event && !sw_count |=> count_r == COUNT_MAX)
    else $error("underflow did not load all ones");
  flag_set_a: assert property (wrap && !serial && !clkout |=> ctl_r[CTL_OVERFLOW] && timer_irq_out)
    else $error("overflow flag or request missing");
  serial_flag_a: assert property (serial && !ctl_r[CTL_OVERFLOW] && !sw_ctl |=> !ctl_r[CTL_OVERFLOW])
    else $error("overflow flag set while clocking serial port");
  ext_toggle_a: assert property (updown && wrap && !sw_ctl |=> ctl_r[CTL_EXTERNAL] != $past(ctl_r[CTL_EXTERNAL]))
    else $error("external flag did not toggle");
  clk_pin_a: assert property (clkout && wrap && !sw_ctl |=> count_pin_out != $past(count_pin_out) && count_pin_oe_out)
    else $error("clock output did not toggle");
  capture_a: assert property (ext_event && capture_mode && !sw_reload |=> reload_r == $past(count_r))
    else $error("capture did not store count");

  up_wrap_c:   cover property (wrap_up && updown);
  down_wrap_c: cover property (wrap_down);
  clkout_c:    cover property (clkout && wrap ##[1:300] clkout && wrap);

endmodule // updown_reload_clockout_timer
`default_nettype wire

// ==== testbench/pin_partner.sv ====
// Purpose: Far side model of the count pin and the direction pin
// Assumes: Tasks are called just after a rising clock edge
// Notes:   Count pin idles high so a reset synchroniser sees no edge
`timescale 1ns/1ps
`default_nettype none

module pin_partner (
  input  wire logic clk_in,
  input  wire logic count_pin_out,
  input  wire logic count_pin_oe_out,
  output logic      pin_level_out,
  output logic      dir_level_out
);
  logic drv_r;

  // Device wins the pin while it drives the clock out
  assign pin_level_out = count_pin_oe_out ? count_pin_out : drv_r;

  initial begin
    drv_r = 1'b1;
    dir_level_out = 1'b1;
  end

  // Four cycles each way clears the two-flop synchroniser
  task automatic pulse();
    drv_r <= 1'b0;
    repeat (4) @(posedge clk_in);
    drv_r <= 1'b1;
    repeat (4) @(posedge clk_in);
  endtask

  task automatic set_dir(input logic v);
    dir_level_out <= v;
    repeat (4) @(posedge clk_in);
  endtask
endmodule // pin_partner
`default_nettype wire

// ==== testbench/updown_reload_clockout_timer_test.sv ====
// Purpose: Self-checking bench for the up/down reload clock-out timer
// Assumes: Zero wait state slave; byte address is index times four
// Notes:   Expectations come from the register map and pin rules only
`timescale 1ns/1ps
`default_nettype none

module updown_reload_clockout_timer_test;
  import timer_two_pkg::*;
  localparam logic [31:0] A_CTL = {22'h0, IDX_CONTROL, 2'b00};
  localparam logic [31:0] A_MOD = {22'h0, IDX_MODE, 2'b00};
  localparam logic [31:0] A_CLO = {22'h0, IDX_COUNT_LOW, 2'b00};
  localparam logic [31:0] A_CHI = {22'h0, IDX_COUNT_HIGH, 2'b00};
  localparam logic [31:0] A_RLO = {22'h0, IDX_RELOAD_LOW, 2'b00};
  localparam logic [31:0] A_RHI = {22'h0, IDX_RELOAD_HIGH, 2'b00};
  logic clk_in, rst_n_in, hsel, hwrite, hready, hresp, pin_in, pin_out, pin_oe, dir, irq, tick;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  int          error_cnt, checks;

  updown_reload_clockout_timer dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .count_pin_in(pin_in), .count_pin_out(pin_out), .count_pin_oe_out(pin_oe),
    .direction_capture_pin_in(dir), .timer_irq_out(irq), .serial_clock_tick_out(tick));
  pin_partner part_u (.clk_in(clk_in), .count_pin_out(pin_out), .count_pin_oe_out(pin_oe),
    .pin_level_out(pin_in), .dir_level_out(dir));

  // ---------------------------------------------------------------
  // Bus and compare helpers
  // ---------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits on hready without a limit of its own; the watchdog ends a hung bus
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    htrans <= HTRANS_NONSEQ;
    do @(posedge clk_in); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_in); while (hready !== 1'b1);
    rd = hrdata;
    if (hresp !== HRESP_OKAY) cmp({31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask

  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    xfer(1'b0, a, 32'h0, d);
    cmp(d, e);
  endtask

  task automatic set16(input logic [31:0] lo, input logic [15:0] v);
    wr(lo, {24'h0, v[7:0]});
    wr(lo + 32'h4, {24'h0, v[15:8]});
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk(A_CTL, 32'h0);
    chk(A_MOD, 32'h0);
    chk(A_CHI, 32'h0);
    chk(32'h400, 32'h0);
  endtask

  task automatic t_counter();
    set16(A_CLO, 16'h00ff);
    wr(A_CTL, 32'h06);
    part_u.pulse();
    chk(A_CLO, 32'h00);
    chk(A_CHI, 32'h01);
    wr(A_CTL, 32'h02);
    part_u.pulse();
    chk(A_CLO, 32'h00);
  endtask

  task automatic t_timer();
    int n;
    n = 0;
    set16(A_RLO, 16'hff00);
    set16(A_CLO, 16'hfffe);
    wr(A_CTL, 32'h04);
    while (irq !== 1'b1 && n < 100) begin @(posedge clk_in); n++; end
    cmp({31'h0, irq}, 32'h1);
    chk(A_CTL, 32'h84);
    chk(A_CHI, 32'hff);
    wr(A_CTL, 32'h00);
    // The request register clears on the same edge as the flag, when the clearing write lands
    @(posedge clk_in);
    cmp({31'h0, irq}, 32'h0);
  endtask

  task automatic t_updown();
    wr(A_MOD, 32'h1);
    part_u.set_dir(1'b0);
    set16(A_RLO, 16'h0010);
    set16(A_CLO, 16'h0011);
    wr(A_CTL, 32'h06);
    part_u.pulse();
    part_u.pulse();
    chk(A_CLO, 32'hff);
    chk(A_CHI, 32'hff);
    chk(A_CTL, 32'hc6);
    part_u.set_dir(1'b1);
    part_u.pulse();
    chk(A_CLO, 32'h10);
    chk(A_CTL, 32'h86);
    wr(A_CTL, 32'h00);
    wr(A_MOD, 32'h0);
  endtask

  task automatic t_capture();
    set16(A_CLO, 16'h1234);
    wr(A_CTL, 32'h09);
    part_u.set_dir(1'b0);
    part_u.set_dir(1'b1);
    chk(A_RLO, 32'h34);
    chk(A_RHI, 32'h12);
    chk(A_CTL, 32'h49);
    cmp({31'h0, irq}, 32'h1);
    wr(A_CTL, 32'h08);
    set16(A_RLO, 16'h5678);
    part_u.set_dir(1'b0);
    part_u.set_dir(1'b1);
    chk(A_CHI, 32'h56);
    wr(A_CTL, 32'h00);
  endtask

  // Eighty cycles after a toggle hold exactly twenty wraps at a four-cycle wrap period
  task automatic measure(input logic [31:0] ctl, input logic [31:0] tk_exp);
    int tg, tk;
    logic last;
    tg = 0;
    tk = 0;
    wr(A_CTL, ctl);
    last = pin_out;
    // Line up on a toggle first, so the window does not hang on the fast tick phase
    repeat (16) begin
      @(posedge clk_in);
      if (pin_out !== last) break;
    end
    last = pin_out;
    repeat (80) begin
      @(posedge clk_in);
      if (pin_out !== last) tg++;
      if (tick === 1'b1) tk++;
      last = pin_out;
    end
    cmp({31'h0, pin_oe}, 32'h1);
    cmp(tg, 32'd20);
    cmp(tk, tk_exp);
    chk(A_CTL, ctl);
  endtask

  task automatic t_clock_out();
    wr(A_MOD, 32'h2);
    wr(A_CTL, 32'h00);
    set16(A_RLO, 16'hfffe);
    set16(A_CLO, 16'hfffe);
    measure(32'h04, 32'd0);
    measure(32'h14, 32'd20);
    wr(A_CTL, 32'h00);
  endtask

  // ---------------------------------------------------------------
  // Clock, reset, sequence and verdict
  // ---------------------------------------------------------------
  task automatic results();
    $display("Checks %0d, errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    results();
  end

  initial begin
    error_cnt = 0;
    checks = 0;
    rst_n_in = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hsize = 3'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    t_reset();
    t_counter();
    t_timer();
    t_updown();
    t_capture();
    t_clock_out();
    results();
  end
endmodule // updown_reload_clockout_timer_test
`default_nettype wire
